/* hw/uff_channel.v */
// one uart channel: enhanced-bit gating, special char, hardware flow, fifo levels
`timescale 1ns/100ps
`include "uff_defines.vh"
module uff_channel (
  input  wire       ref_clk_i,
  input  wire       nrst_i,
  input  wire [4:0] reg_addr_i,
  input  wire       reg_wr_i,
  input  wire       reg_rd_i,
  input  wire [7:0] reg_wdata_i,
  output wire [7:0] reg_rdata_o,
  input  wire       rx_char_valid_i,
  input  wire [7:0] rx_char_i,
  input  wire       rx_unload_i,
  output wire       rx_store_o,
  input  wire       tx_load_i,
  input  wire       tx_take_i,
  input  wire       tx_idle_i,
  input  wire       tx_serial_i,
  input  wire       ir_serial_i,
  output wire       tx_o,
  output wire       infrared_tx_out_o,
  output wire       tx_hold_o,
  input  wire       cts_n_i,
  input  wire       dsr_n_i,
  input  wire       dcd_n_i,
  input  wire       ri_n_i,
  output wire       rts_n_o,
  output wire       dtr_n_o,
  output wire       irq_o
);

  reg  [7:0] ier_q;
  reg  [7:0] fcr_q;
  reg  [7:0] lcr_q;
  reg  [7:0] mcr_q;
  reg  [7:0] lsr_q;
  reg  [7:0] spr_q;
  reg  [7:0] feature_control_reg_q;
  reg  [7:0] efr_q;
  reg  [7:0] tx_fifo_level_count_q;
  reg  [7:0] tx_fifo_trigger_level_q;
  reg  [7:0] rx_fifo_level_count_q;
  reg  [7:0] rx_fifo_trigger_level_q;
  reg  [7:0] flow_char_status_q;
  reg  [7:0] start_char_one_q;
  reg  [7:0] start_char_two_q;
  reg  [7:0] stop_char_one_q;
  reg  [7:0] stop_char_two_q;
  reg  [3:0] msr_delta_q;
  reg  [3:0] pin_s1_q;
  reg  [3:0] pin_s2_q;
  reg  [3:0] pin_s3_q;
  reg  [2:0] prime_q;
  reg        spec_flag_q;
  reg        stop_flag_q;
  reg        flow_stop_q;
  reg  [7:0] rdata_q;
  reg        tx_q;
  reg        irout_q;

  wire       wr_en   = reg_wr_i;
  wire       enh_en  = efr_q[`UFF_EFR_ENH];
  wire [1:0] rx_cmp  = efr_q[1:0];
  wire [3:0] pin_lvl = ~pin_s2_q;   // cts, dsr, ri, dcd as asserted-high bits

  // per-register write and read strobes
  wire wr_ier   = wr_en && (reg_addr_i == `UFF_IDX_IER);
  wire wr_fcr   = wr_en && (reg_addr_i == `UFF_IDX_ISR);
  wire wr_lcr   = wr_en && (reg_addr_i == `UFF_IDX_LCR);
  wire wr_mcr   = wr_en && (reg_addr_i == `UFF_IDX_MCR);
  wire wr_spr   = wr_en && (reg_addr_i == `UFF_IDX_SPR);
  wire wr_feature_control_reg  = wr_en && (reg_addr_i == `UFF_IDX_FEATURE_CONTROL_REG);
  wire wr_efr   = wr_en && (reg_addr_i == `UFF_IDX_EFR);
  wire wr_tx_fifo_trigger_level = wr_en && (reg_addr_i == `UFF_IDX_TXLVL);
  wire wr_rx_fifo_trigger_level = wr_en && (reg_addr_i == `UFF_IDX_RXLVL);
  wire rd_isr   = reg_rd_i && (reg_addr_i == `UFF_IDX_ISR);
  wire rd_msr   = reg_rd_i && (reg_addr_i == `UFF_IDX_MSR);
  wire rd_flow_char_status = reg_rd_i && (reg_addr_i == `UFF_IDX_FLOW_CHAR_STATUS);

  // special char and stop char detection on each received character
  wire spec_hit = rx_char_valid_i && efr_q[`UFF_EFR_SPEC]
                  && (rx_char_i == stop_char_two_q);                       // [RQ5]
  wire drop_chr = spec_hit && (rx_cmp == `UFF_CMP_PAIR2);          // [RQ7]
  wire stop_hit = rx_char_valid_i && (((rx_cmp == `UFF_CMP_PAIR1) && (rx_char_i == stop_char_one_q))
                  || ((rx_cmp[0]) && (rx_char_i == stop_char_two_q)));     // [RQ6] [RQ20]
  wire rx_full  = (rx_fifo_level_count_q == `UFF_DEPTH);
  wire tx_full  = (tx_fifo_level_count_q == `UFF_DEPTH);
  wire rx_put   = rx_char_valid_i && !drop_chr && !rx_full;        // [RQ21]
  wire rx_get   = rx_unload_i && (rx_fifo_level_count_q != 8'h00);
  wire tx_put   = tx_load_i && !tx_full;                           // [RQ21]
  wire tx_get   = tx_take_i && (tx_fifo_level_count_q != 8'h00);

  assign rx_store_o = rx_put;                                      // [RQ5]

  // hysteresis lookup; zero code or non table-d falls back to next trigger step
  function [7:0] hyst_of;
    input [7:0] feature_control_reg;
    begin
      case (feature_control_reg[3:0])
        4'h1:    hyst_of = 8'h04;
        4'h2:    hyst_of = 8'h06;
        4'h3:    hyst_of = 8'h08;
        4'h4:    hyst_of = 8'h08;
        4'h5:    hyst_of = 8'h10;
        4'h6:    hyst_of = 8'h18;
        4'h7:    hyst_of = 8'h20;
        4'hC:    hyst_of = 8'h0C;
        4'hD:    hyst_of = 8'h14;
        4'hE:    hyst_of = 8'h1C;
        4'hF:    hyst_of = 8'h24;
        4'h8:    hyst_of = 8'h28;
        4'h9:    hyst_of = 8'h2C;
        4'hA:    hyst_of = 8'h30;
        4'hB:    hyst_of = 8'h34;
        default: hyst_of = `UFF_NEXT_STEP;
      endcase
      if (feature_control_reg[7:6] != `UFF_TABLE_D) begin
        hyst_of = `UFF_NEXT_STEP;
      end
    end
  endfunction

  // flow thresholds kept in 9 bits so trigger plus step cannot wrap
  wire [7:0] hyst     = hyst_of(feature_control_reg_q);
  wire [8:0] up_lvl   = {1'b0, rx_fifo_trigger_level_q} + {1'b0, hyst};
  wire [8:0] lo_lvl   = (rx_fifo_trigger_level_q > hyst) ? ({1'b0, rx_fifo_trigger_level_q} - {1'b0, hyst}) : 9'h000;
  wire       sel_dtr  = mcr_q[`UFF_MCR_SEL];                          // [RQ11]
  wire       sw_assert = sel_dtr ? mcr_q[`UFF_MCR_DTR] : mcr_q[`UFF_MCR_RTS];
  wire       auto_rts = efr_q[`UFF_EFR_ARTS] && sw_assert;            // [RQ10]

  // trigger interrupts
  wire rx_trig  = (rx_fifo_level_count_q >= rx_fifo_trigger_level_q);                               // [RQ17]
  wire tx_trig  = (tx_fifo_level_count_q < tx_fifo_trigger_level_q);                                // [RQ15]
  wire msr_int  = |msr_delta_q;
  wire spec_int = spec_flag_q | stop_flag_q;
  wire pend_rx  = ier_q[0] && rx_trig;                                // [RQ8]
  wire pend_tx  = ier_q[1] && tx_trig;
  wire pend_ms  = ier_q[3] && msr_int;
  wire pend_sp  = ier_q[5] && spec_int;
  wire pending  = pend_rx | pend_tx | pend_ms | pend_sp;
  assign irq_o  = pending;

  // interrupt status view: priority code low nibble, enhanced flags in bits 5-4
  reg [7:0] isr_view;
  always @* begin
    isr_view = `UFF_RST_ISR;
    if (pend_rx) begin
      isr_view = 8'h04;
    end else if (pend_tx) begin
      isr_view = 8'h02;
    end else if (pend_ms) begin
      isr_view = 8'h00;
    end else if (pend_sp) begin
      isr_view = 8'h10;
    end
    isr_view[4] = isr_view[4] | spec_flag_q;                          // [RQ5]
    isr_view[5] = stop_flag_q;                                        // [RQ7]
    isr_view[7:6] = {fcr_q[0], fcr_q[0]};
  end

  // read multiplexer; unmapped indices read zero
  reg [7:0] rd_mux;
  always @* begin
    case (reg_addr_i)
      `UFF_IDX_IER:   rd_mux = ier_q;
      `UFF_IDX_ISR:   rd_mux = isr_view;
      `UFF_IDX_LCR:   rd_mux = lcr_q;
      `UFF_IDX_MCR:   rd_mux = mcr_q;
      `UFF_IDX_LSR:   rd_mux = lsr_q;
      `UFF_IDX_MSR:   rd_mux = {pin_lvl, msr_delta_q};                // [RQ19]
      `UFF_IDX_SPR:   rd_mux = spr_q;
      `UFF_IDX_FEATURE_CONTROL_REG:  rd_mux = feature_control_reg_q;
      `UFF_IDX_EFR:   rd_mux = efr_q;
      `UFF_IDX_TXLVL: rd_mux = tx_fifo_level_count_q;                               // [RQ14]
      `UFF_IDX_RXLVL: rd_mux = rx_fifo_level_count_q;                               // [RQ16]
      `UFF_IDX_FLOW_CHAR_STATUS: rd_mux = flow_char_status_q;
      `UFF_IDX_START_CHAR_ONE:  rd_mux = start_char_one_q;
      `UFF_IDX_START_CHAR_TWO:  rd_mux = start_char_two_q;
      `UFF_IDX_STOP_CHAR_ONE: rd_mux = stop_char_one_q;
      `UFF_IDX_STOP_CHAR_TWO: rd_mux = stop_char_two_q;
      default:        rd_mux = 8'h00;
    endcase
  end

  // modem input synchroniser; stage three only for delta edge detection
  // prime keeps deltas off until stage three holds real pin levels,
  // else a pin held low through reset shows a false change afterwards
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pin_s1_q <= 4'hF;
      pin_s2_q <= 4'hF;
      pin_s3_q <= 4'hF;
      prime_q  <= 3'h0;
    end else begin
      pin_s1_q <= {dcd_n_i, ri_n_i, dsr_n_i, cts_n_i};
      pin_s2_q <= pin_s1_q;
      pin_s3_q <= pin_s2_q;
      prime_q  <= {prime_q[1:0], 1'b1};
    end
  end

  // control registers; gated enhanced bits hold unless the enable is set
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ier_q   <= `UFF_RST_ZERO;                                       // [RQ3]
      fcr_q   <= `UFF_RST_ZERO;                                       // [RQ3]
      lcr_q   <= `UFF_RST_ZERO;
      mcr_q   <= `UFF_RST_ZERO;                                       // [RQ3]
      spr_q   <= `UFF_RST_SPR;                                        // [RQ18]
      feature_control_reg_q  <= `UFF_RST_ZERO;
      efr_q   <= `UFF_RST_ZERO;
      tx_fifo_trigger_level_q <= `UFF_RST_ZERO;
      rx_fifo_trigger_level_q <= `UFF_RST_ZERO;
      start_char_one_q  <= `UFF_RST_ZERO;
      start_char_two_q  <= `UFF_RST_ZERO;
      stop_char_one_q <= `UFF_RST_ZERO;
      stop_char_two_q <= `UFF_RST_ZERO;
    end else begin
      if (wr_ier) begin
        ier_q <= enh_en ? reg_wdata_i
                 : ((ier_q & `UFF_IER_GATE) | (reg_wdata_i & ~`UFF_IER_GATE)); // [RQ1] [RQ2]
      end
      if (wr_fcr) begin
        fcr_q <= enh_en ? reg_wdata_i
                 : ((fcr_q & `UFF_FCR_GATE) | (reg_wdata_i & ~`UFF_FCR_GATE)); // [RQ1] [RQ2]
      end
      if (wr_mcr) begin
        mcr_q <= enh_en ? reg_wdata_i
                 : ((mcr_q & `UFF_MCR_GATE) | (reg_wdata_i & ~`UFF_MCR_GATE)); // [RQ1] [RQ2]
      end
      if (wr_lcr) begin
        lcr_q <= reg_wdata_i;
      end
      if (wr_spr) begin
        spr_q <= reg_wdata_i;
      end
      if (wr_feature_control_reg) begin
        feature_control_reg_q <= reg_wdata_i;
      end
      if (wr_efr) begin
        efr_q <= reg_wdata_i;                                         // [RQ20]
      end
      if (wr_tx_fifo_trigger_level) begin
        tx_fifo_trigger_level_q <= reg_wdata_i;                                       // [RQ15]
      end
      if (wr_rx_fifo_trigger_level) begin
        rx_fifo_trigger_level_q <= reg_wdata_i;                                       // [RQ17]
      end
      if (wr_en && (reg_addr_i == `UFF_IDX_START_CHAR_ONE)) begin
        start_char_one_q <= reg_wdata_i;
      end
      if (wr_en && (reg_addr_i == `UFF_IDX_START_CHAR_TWO)) begin
        start_char_two_q <= reg_wdata_i;
      end
      if (wr_en && (reg_addr_i == `UFF_IDX_STOP_CHAR_ONE)) begin
        stop_char_one_q <= reg_wdata_i;
      end
      if (wr_en && (reg_addr_i == `UFF_IDX_STOP_CHAR_TWO)) begin
        stop_char_two_q <= reg_wdata_i;
      end
    end
  end

  // fifo level counters; push and pop in one cycle cancel
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_fifo_level_count_q <= `UFF_RST_ZERO;
      rx_fifo_level_count_q <= `UFF_RST_ZERO;
    end else begin
      if (tx_put && !tx_get) begin
        tx_fifo_level_count_q <= tx_fifo_level_count_q + 8'h01;                                   // [RQ14]
      end else if (tx_get && !tx_put) begin
        tx_fifo_level_count_q <= tx_fifo_level_count_q - 8'h01;
      end
      if (rx_put && !rx_get) begin
        rx_fifo_level_count_q <= rx_fifo_level_count_q + 8'h01;                                   // [RQ16]
      end else if (rx_get && !rx_put) begin
        rx_fifo_level_count_q <= rx_fifo_level_count_q - 8'h01;
      end
    end
  end

  // sticky flags; a new event in the clearing read's cycle wins
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      spec_flag_q <= 1'b0;
      stop_flag_q <= 1'b0;
      flow_char_status_q     <= `UFF_RST_ZERO;
      msr_delta_q <= 4'h0;                                            // [RQ19]
    end else begin
      spec_flag_q <= spec_hit | (spec_flag_q & ~rd_isr);              // [RQ5]
      stop_flag_q <= (stop_hit && (drop_chr || !spec_hit))
                     | (stop_flag_q & ~rd_isr);                       // [RQ7]
      flow_char_status_q     <= {7'h00, stop_hit | (flow_char_status_q[0] & ~rd_flow_char_status)};
      msr_delta_q <= ((pin_s2_q ^ pin_s3_q) & {4{prime_q[2]}})
                     | (msr_delta_q & {4{~rd_msr}});                  // [RQ19]
    end
  end

  // line status: rx data ready, holding empty, transmitter empty
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      lsr_q <= `UFF_RST_LSR;                                          // [RQ18]
    end else begin
      lsr_q <= {1'b0, (tx_fifo_level_count_q == 8'h00) && tx_idle_i, tx_fifo_level_count_q == 8'h00,
                4'h0, rx_fifo_level_count_q != 8'h00};
    end
  end

  // auto request: stop the far end at or above upper level, release below lower level
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      flow_stop_q <= 1'b0;
    end else if (!auto_rts) begin
      flow_stop_q <= 1'b0;                                            // [RQ10]
    end else if ({1'b0, rx_fifo_level_count_q} >= up_lvl) begin
      flow_stop_q <= 1'b1;                                            // [RQ8]
    end else if ({1'b0, rx_fifo_level_count_q} < lo_lvl) begin
      flow_stop_q <= 1'b0;                                            // [RQ9]
    end
  end

  // request/ready pins; plain outputs unless auto flow owns the selected one
  wire rts_plain = ~mcr_q[`UFF_MCR_RTS];                              // [RQ12]
  wire dtr_plain = ~mcr_q[`UFF_MCR_DTR];                              // [RQ12]
  assign rts_n_o = (auto_rts && !sel_dtr) ? flow_stop_q : rts_plain;  // [RQ11]
  assign dtr_n_o = (auto_rts && sel_dtr) ? flow_stop_q : dtr_plain;   // [RQ11] [RQ19]

  // auto clear flow: selected synchronised input high holds the transmitter
  wire flow_in_n = sel_dtr ? pin_s2_q[1] : pin_s2_q[0];               // [RQ11]
  assign tx_hold_o = efr_q[`UFF_EFR_ACTS] && flow_in_n;               // [RQ13]

  // serial outputs registered so reset shows idle levels
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      tx_q    <= 1'b1;                                                // [RQ19]
      irout_q <= 1'b0;                                                // [RQ19]
    end else begin
      tx_q    <= tx_serial_i;
      irout_q <= ir_serial_i;
    end
  end
  assign tx_o              = tx_q;
  assign infrared_tx_out_o = irout_q;

  // read data captured on the read strobe
  always @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      rdata_q <= 8'h00;
    end else if (reg_rd_i) begin
      rdata_q <= rd_mux;
    end
  end
  assign reg_rdata_o = rdata_q;

endmodule // uff_channel

/* hw/uff_defines.vh */
// register map, field positions, reset values and levels of the flow/fifo-level channel
// How it works
// RQ1: enhanced interrupt-enable, status, fifo and modem bits writable only while enable set
// RQ2: clearing the enable bit freezes enhanced bits; legacy writes leave them alone
// RQ3: reset clears every gated enhanced bit for legacy behaviour
// RQ4: software is advised to keep the enhanced enable bit set
// RQ5: special detect compares each received char with stop char two, flags status bit 4
// RQ6: compare code 10 lets special detect and flow control run independently
// RQ7: compare code 01 drops matching stop char two, raises stop and special interrupts
// RQ8: auto request flags rx trigger, deasserts pin at upper trigger or hysteresis level
// RQ9: auto request reasserts pin once rx level falls below lower trigger or hysteresis
// RQ10: auto request acts only after software asserted the request output
// RQ11: modem-control bit 2 picks request or ready output and clear or set-ready input
// RQ12: without hardware flow the request pin follows the modem-control bit
// RQ13: auto clear flow halts transmit while selected input high, resumes when low
// RQ14: read-only tx fifo count from 0 to 64
// RQ15: write-only tx trigger; interrupt while tx level is below it
// RQ16: read-only rx fifo count from 0 to 64
// RQ17: write-only rx trigger; interrupt once rx level reaches it
// RQ18: reset values: status 0x01, line status 0x60, scratch 0xFF, others zero
// RQ19: reset clears modem deltas, shows pin levels, tx high, infrared low, outputs high
// RQ20: enhanced bits 3-2 pick transmit flow chars, bits 1-0 the receive compare; here bits 3-2 drive nothing
// RQ21: fifos hold 64 chars, counters saturate at 64
`ifndef UFF_DEFINES_VH
`define UFF_DEFINES_VH
// register indices on the register port
`define UFF_IDX_IER     5'h01
`define UFF_IDX_ISR     5'h02
`define UFF_IDX_LCR     5'h03
`define UFF_IDX_MCR     5'h04
`define UFF_IDX_LSR     5'h05
`define UFF_IDX_MSR     5'h06
`define UFF_IDX_SPR     5'h07
`define UFF_IDX_FEATURE_CONTROL_REG    5'h08
`define UFF_IDX_EFR     5'h09
`define UFF_IDX_TXLVL   5'h0A
`define UFF_IDX_RXLVL   5'h0B
`define UFF_IDX_FLOW_CHAR_STATUS   5'h0C
`define UFF_IDX_START_CHAR_ONE    5'h0D
`define UFF_IDX_START_CHAR_TWO    5'h0E
`define UFF_IDX_STOP_CHAR_ONE   5'h0F
`define UFF_IDX_STOP_CHAR_TWO   5'h10
// reset values
`define UFF_RST_ZERO    8'h00
`define UFF_RST_ISR     8'h01
`define UFF_RST_LSR     8'h60
`define UFF_RST_SPR     8'hFF
// fields
`define UFF_EFR_ENH     4
`define UFF_EFR_SPEC    5
`define UFF_EFR_ARTS    6
`define UFF_EFR_ACTS    7
`define UFF_MCR_DTR     0
`define UFF_MCR_RTS     1
`define UFF_MCR_SEL     2
`define UFF_IER_GATE    8'hF0
`define UFF_FCR_GATE    8'h30
`define UFF_MCR_GATE    8'hE0
// receive compare codes
`define UFF_CMP_PAIR1   2'b10
`define UFF_CMP_PAIR2   2'b01
// fifo depth and next-trigger step for non table-d mode
`define UFF_DEPTH       8'h40
`define UFF_NEXT_STEP   8'h04
`define UFF_TABLE_D     2'b11
`endif

/* verif/uart_flow_control_fifo_levels_tb_top.sv */
// self-checking bench for the flow/fifo-level channel
`timescale 1ns/100ps
`include "uff_defines.vh"
module uart_flow_control_fifo_levels_tb_top;
  localparam logic R = 1'b0;
  localparam logic W = 1'b1;
  logic       clk, nrst, wr_en, rd_en, unload, tload, take, txs;
  logic [4:0] addr;
  logic [7:0] wdata, v;
  wire  [7:0] rdata, rch;
  wire        valid, store, txo, iro, hold, rts_n, dtr_n, irq, cts_n, dsr_n;
  int         error_cnt, checked;
  logic [13:0] rows [0:32] = '{
    {R, `UFF_IDX_ISR, 8'h01}, {R, `UFF_IDX_LSR, 8'h60}, {R, `UFF_IDX_SPR, 8'hFF},
    {R, `UFF_IDX_IER, 8'h00}, {R, `UFF_IDX_LCR, 8'h00}, {R, `UFF_IDX_MCR, 8'h00},
    {R, `UFF_IDX_MSR, 8'h00}, {R, `UFF_IDX_FEATURE_CONTROL_REG, 8'h00}, {R, `UFF_IDX_EFR, 8'h00},
    {R, `UFF_IDX_TXLVL, 8'h00}, {R, `UFF_IDX_RXLVL, 8'h00}, {R, `UFF_IDX_FLOW_CHAR_STATUS, 8'h00},
    {R, `UFF_IDX_START_CHAR_ONE, 8'h00}, {R, `UFF_IDX_START_CHAR_TWO, 8'h00}, {R, `UFF_IDX_STOP_CHAR_ONE, 8'h00},
    {R, `UFF_IDX_STOP_CHAR_TWO, 8'h00}, {R, 5'h1F, 8'h00}, {W, `UFF_IDX_SPR, 8'h5A},
    {R, `UFF_IDX_SPR, 8'h5A}, {W, `UFF_IDX_IER, 8'hF3}, {R, `UFF_IDX_IER, 8'h03},
    {W, `UFF_IDX_EFR, 8'h10}, {W, `UFF_IDX_IER, 8'hF3}, {R, `UFF_IDX_IER, 8'hF3},
    {W, `UFF_IDX_EFR, 8'h00}, {W, `UFF_IDX_IER, 8'h0C}, {R, `UFF_IDX_IER, 8'hFC},
    {W, `UFF_IDX_MCR, 8'hE3}, {R, `UFF_IDX_MCR, 8'h03}, {W, `UFF_IDX_MCR, 8'h00},
    {W, `UFF_IDX_EFR, 8'h10}, {W, `UFF_IDX_IER, 8'h00}, {R, `UFF_IDX_IER, 8'h00}};

  uff_channel i_dut (
    .ref_clk_i(clk), .nrst_i(nrst), .reg_addr_i(addr), .reg_wr_i(wr_en),
    .reg_rd_i(rd_en), .reg_wdata_i(wdata), .reg_rdata_o(rdata), .rx_char_valid_i(valid),
    .rx_char_i(rch), .rx_unload_i(unload), .rx_store_o(store), .tx_load_i(tload),
    .tx_take_i(take), .tx_idle_i(1'b1), .tx_serial_i(txs), .ir_serial_i(1'b1),
    .tx_o(txo), .infrared_tx_out_o(iro), .tx_hold_o(hold), .cts_n_i(cts_n),
    .dsr_n_i(dsr_n), .dcd_n_i(1'b1), .ri_n_i(1'b1), .rts_n_o(rts_n), .dtr_n_o(dtr_n),
    .irq_o(irq));
  uff_remote i_rem (
    .clk_i(clk), .valid_o(valid), .char_o(rch), .cts_n_o(cts_n), .dsr_n_o(dsr_n));

  task automatic cmp8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cmp1(input logic got, input logic exp);
    cmp8({7'h00, got}, {7'h00, exp});
  endtask
  task automatic settle();
    repeat (3) @(negedge clk);
  endtask
  task automatic wr_reg(input logic [4:0] a, input logic [7:0] d);
    @(posedge clk);
    addr  <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
    @(negedge clk);
  endtask
  // read and compare under a mask; data lands one edge after the strobe
  task automatic chk(input logic [4:0] a, input logic [7:0] m, input logic [7:0] e);
    @(posedge clk);
    addr  <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    @(negedge clk);
    cmp8(rdata & m, e);
  endtask
  // k: 0 rx unload, 1 tx load, 2 tx take
  task automatic pulse(input int n, input int k);
    repeat (n) begin
      @(posedge clk);
      unload <= (k == 0);
      tload  <= (k == 1);
      take   <= (k == 2);
      @(posedge clk);
      {unload, tload, take} <= 3'h0;
    end
    settle();
  endtask
  task automatic rx(input int n, input logic [7:0] c);
    i_rem.send(n, c);
    settle();
  endtask
  task automatic stop_test();
    $display("checked %0d error_cnt %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  // watchdog at 20000 cycles, well past the expected run of under a thousand cycles
  initial begin
    #200000;
    error_cnt++;
    stop_test();
  end
  initial begin
    {nrst, wr_en, rd_en, unload, tload, take, txs} = 7'h00;
    addr = 5'h00;
    wdata = 8'h00;
    repeat (10) @(posedge clk);
    @(negedge clk);
    cmp1(txo, 1'b1);
    cmp1(iro, 1'b0);
    cmp1(rts_n, 1'b1);
    cmp1(dtr_n, 1'b1);
    @(posedge clk);
    nrst <= 1'b1;
    txs  <= 1'b1;
    foreach (rows[i]) begin
      if (rows[i][13]) wr_reg(rows[i][12:8], rows[i][7:0]);
      else chk(rows[i][12:8], 8'hFF, rows[i][7:0]);
    end
    // tx level past depth, then drain across the trigger boundary
    wr_reg(`UFF_IDX_IER, 8'h02);
    wr_reg(`UFF_IDX_TXLVL, 8'h14);
    pulse(65, 1);
    chk(`UFF_IDX_TXLVL, 8'hFF, 8'h40);
    pulse(44, 2);
    cmp1(irq, 1'b0);
    pulse(1, 2);
    cmp1(irq, 1'b1);
    pulse(20, 2);
    chk(`UFF_IDX_TXLVL, 8'hFF, 8'h00);
    // auto request with trigger 16: stop at 20, release below 12
    wr_reg(`UFF_IDX_EFR, 8'h50);
    wr_reg(`UFF_IDX_MCR, 8'h02);
    wr_reg(`UFF_IDX_RXLVL, 8'h10);
    wr_reg(`UFF_IDX_IER, 8'h01);
    rx(15, 8'h41);
    cmp1(irq, 1'b0);
    rx(1, 8'h41);
    cmp1(irq, 1'b1);
    rx(3, 8'h41);
    cmp1(rts_n, 1'b0);
    rx(1, 8'h41);
    cmp1(rts_n, 1'b1);
    rx(45, 8'h41);
    chk(`UFF_IDX_RXLVL, 8'hFF, 8'h40);
    pulse(52, 0);
    cmp1(rts_n, 1'b1);
    pulse(1, 0);
    cmp1(rts_n, 1'b0);
    wr_reg(`UFF_IDX_MCR, 8'h07);
    rx(9, 8'h41);
    cmp1(dtr_n, 1'b1);
    cmp1(rts_n, 1'b0);
    wr_reg(`UFF_IDX_EFR, 8'h10);
    cmp1(dtr_n, 1'b0);
    wr_reg(`UFF_IDX_MCR, 8'h00);
    pulse(20, 0);
    wr_reg(`UFF_IDX_IER, 8'h00);
    // special char under compare code 01, then code 10
    wr_reg(`UFF_IDX_STOP_CHAR_TWO, 8'h7E);
    wr_reg(`UFF_IDX_EFR, 8'h31);
    rx(1, 8'h7E);
    chk(`UFF_IDX_RXLVL, 8'hFF, 8'h00);
    chk(`UFF_IDX_ISR, 8'h30, 8'h30);
    wr_reg(`UFF_IDX_EFR, 8'h32);
    rx(1, 8'h7E);
    chk(`UFF_IDX_RXLVL, 8'hFF, 8'h01);
    chk(`UFF_IDX_ISR, 8'h30, 8'h10);
    // auto clear flow on either pin
    wr_reg(`UFF_IDX_EFR, 8'h80);
    i_rem.pins(1'b1, 1'b0);
    settle();
    cmp1(hold, 1'b1);
    wr_reg(`UFF_IDX_MCR, 8'h04);
    cmp1(hold, 1'b0);
    i_rem.pins(1'b0, 1'b1);
    settle();
    cmp1(hold, 1'b1);
    i_rem.pins(1'b0, 1'b0);
    settle();
    cmp1(hold, 1'b0);
    // serial copy, then a mid-run reset with enhanced bits set and pins low
    @(posedge clk);
    txs <= 1'b0;
    settle();
    cmp1(txo, 1'b0);
    cmp1(iro, 1'b1);
    wr_reg(`UFF_IDX_EFR, 8'h90);
    wr_reg(`UFF_IDX_IER, 8'hF0);
    chk(`UFF_IDX_IER, 8'hFF, 8'hF0);
    @(posedge clk);
    nrst <= 1'b0;
    settle();
    cmp1(txo, 1'b1);
    cmp1(iro, 1'b0);
    @(posedge clk);
    nrst <= 1'b1;
    settle();
    chk(`UFF_IDX_MSR, 8'hFF, 8'h30);
    chk(`UFF_IDX_IER, 8'hFF, 8'h00);
    chk(`UFF_IDX_RXLVL, 8'hFF, 8'h00);
    stop_test();
  end
endmodule // uart_flow_control_fifo_levels_tb_top

/* verif/uff_checker.sv */
// port-level assertions for the flow/fifo-level channel, bound to the channel
`timescale 1ns/100ps
`include "uff_defines.vh"
module uff_checker (
  input wire logic       ref_clk_i,
  input wire logic       nrst_i,
  input wire logic [4:0] reg_addr_i,
  input wire logic       reg_wr_i,
  input wire logic       reg_rd_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic       rx_char_valid_i,
  input wire logic       rx_unload_i,
  input wire logic       rx_store_o,
  input wire logic       cts_n_i,
  input wire logic       dsr_n_i,
  input wire logic       rts_n_o,
  input wire logic       dtr_n_o,
  input wire logic       tx_hold_o
);
  logic [7:0] cnt_q;
  logic [7:0] trg_q;
  logic [7:0] mcr_q;
  logic [7:0] efr_q;
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);
  // shadows fed only by port traffic, so a stuck design count still shows up
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_q <= 8'h00;
      trg_q <= 8'h00;
      mcr_q <= 8'h00;
      efr_q <= 8'h00;
    end else begin
      if (reg_wr_i && reg_addr_i == `UFF_IDX_MCR) mcr_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `UFF_IDX_EFR) efr_q <= reg_wdata_i;
      if (reg_wr_i && reg_addr_i == `UFF_IDX_RXLVL) trg_q <= reg_wdata_i;
      // a store and an unload in one cycle cancel, as in the fifo itself
      if (rx_store_o && !(rx_unload_i && cnt_q != 8'h00)) cnt_q <= cnt_q + 8'h01;
      else if (!rx_store_o && rx_unload_i && cnt_q != 8'h00) cnt_q <= cnt_q - 8'h01;
    end
  end
  a_rdata_hold: assert property (!$past(reg_rd_i) |-> $stable(reg_rdata_o))
    else $error("read data moved without a read");
  a_store_cause: assert property (rx_store_o |-> rx_char_valid_i)
    else $error("store without a received char");
  a_store_full: assert property (cnt_q == `UFF_DEPTH |-> !rx_store_o)
    else $error("store into a full rx fifo");
  a_rx_fifo_level_count_read: assert property (reg_rd_i && reg_addr_i == `UFF_IDX_RXLVL
    |=> reg_rdata_o == $past(cnt_q)) else $error("rx count read wrong");
  a_gpo_pins: assert property (!efr_q[`UFF_EFR_ARTS]
    |-> rts_n_o == !mcr_q[1] && dtr_n_o == !mcr_q[0]) else $error("pins not from mcr");
  a_flow_stop: assert property (efr_q[`UFF_EFR_ARTS] && mcr_q[2:1] == 2'h1
    && cnt_q >= trg_q + 8'h04 |=> rts_n_o) else $error("request not deasserted");
  a_flow_release: assert property (efr_q[`UFF_EFR_ARTS] && mcr_q[2:1] == 2'h1
    && trg_q >= 8'h04 && cnt_q < trg_q - 8'h04 |=> !rts_n_o) else $error("no reassert");
  a_hold_off: assert property (!efr_q[`UFF_EFR_ACTS] |-> !tx_hold_o)
    else $error("hold without auto clear flow");
  a_hold_pin: assert property (efr_q[`UFF_EFR_ACTS]
    && $past(cts_n_i, 2) == $past(cts_n_i, 3) && $past(dsr_n_i, 2) == $past(dsr_n_i, 3)
    |-> tx_hold_o == (mcr_q[2] ? $past(dsr_n_i, 2) : $past(cts_n_i, 2)))
    else $error("hold does not follow selected pin");
  c_flow_stop: cover property (efr_q[`UFF_EFR_ARTS] && rts_n_o && !mcr_q[2]);
  c_hold: cover property (tx_hold_o);
  c_full: cover property (cnt_q == `UFF_DEPTH && rx_char_valid_i);
endmodule // uff_checker

bind uff_channel uff_checker i_chk (.*);

/* verif/uff_remote.sv */
// remote serial device model: delivers received chars, drives clear/ready pins
`timescale 1ns/100ps
module uff_remote (
  input  wire logic       clk_i,
  output logic            valid_o,
  output logic [7:0]      char_o,
  output logic            cts_n_o,
  output logic            dsr_n_o
);
  initial begin
    valid_o = 1'b0;
    char_o  = 8'hA5;
    cts_n_o = 1'b1;
    dsr_n_o = 1'b1;
  end
  // one char every other cycle; data shows the inverse once released
  task automatic send(input int n, input logic [7:0] c);
    repeat (n) begin
      @(posedge clk_i);
      valid_o <= 1'b1;
      char_o  <= c;
      @(posedge clk_i);
      valid_o <= 1'b0;
      char_o  <= ~c;
    end
  endtask
  task automatic pins(input logic c, input logic d);
    @(posedge clk_i);
    cts_n_o <= c;
    dsr_n_o <= d;
  endtask
endmodule // uff_remote
